/* File: rtl/accum_add_pkg.sv */
// Constants, field layouts and types of the accumulator add unit
package accum_add_pkg;
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] instr_off = 8'h04;
  localparam logic [7:0] operand_off = 8'h08;
  localparam logic [7:0] repeat_off = 8'h0c;
  localparam logic [7:0] acc_off = 8'h10;
  localparam logic [7:0] status_off = 8'h14;
  localparam logic [7:0] page_off = 8'h18;
  localparam logic [7:0] cycles_off = 8'h1c;
  localparam logic [15:0] ctrl_rst = 16'h0000;
  localparam logic [15:0] ctrl_mask = 16'hff73;
  localparam logic [31:0] acc_rst = 32'h00000000;
  localparam logic [8:0] page_rst = 9'h000;
  // Status word fields
  localparam int st_carry = 0;
  localparam int st_ovf = 1;
  localparam int st_busy = 2;
  localparam int st_refused = 3;
  localparam int st_aux_lsb = 4;
  localparam int st_words_lsb = 8;
  localparam int st_mod_lsb = 10;
  localparam int st_addr_lsb = 16;
  // Instruction encodings
  localparam logic [3:0] shift_hi = 4'h2;
  localparam logic [7:0] add16_hi = 8'h61;
  localparam logic [7:0] accumulate_with_carry_op_hi = 8'h60;
  localparam logic [7:0] short_hi = 8'hb8;
  localparam logic [11:0] long_hi = 12'hbf9;
  localparam logic [15:0] abs_word = 16'hbe00;
  localparam logic [2:0] mod_reserved = 3'h3;
  localparam logic [31:0] acc_max = 32'h7fffffff;
  localparam logic [31:0] acc_min = 32'h80000000;
  localparam logic [1:0] words_one = 2'h1;
  localparam logic [1:0] words_two = 2'h2;

  typedef struct packed {
    logic [3:0] data_wait;
    logic [3:0] prog_wait;
    logic rsvd_hi;
    logic same_block;
    logic oper_ext;
    logic code_ext;
    logic [1:0] rsvd_lo;
    logic saturate_mode;
    logic sign_extend_mode;
  } ctrl_t;

  typedef enum logic [2:0] {
    kind_shift, kind_shift16, kind_short, kind_long, kind_accumulate_with_carry_op, kind_abs, kind_bad
  } op_kind_t;

  typedef enum logic {st_idle, st_exec} exec_state_t;
endpackage

/* File: rtl/accumulator_add_unit.sv */
// Accumulator add datapath with APB register access
// Functional notes
// - Shift amount 0 to 15, default zero
// - Direct address: page pointer plus seven bits
// - Next aux field selects pointer zero-seven
// - Seven indirect modifier options decoded
// - Short form adds low byte unshifted
// - Long form shifts second word constant
// - Shifted operand added into accumulator
// - Zero fill low, sign or zero high
// - Short form ignores sign mode, not repeatable
// - Normal shifts: carry set or cleared
// - Shift sixteen: carry only set
// - Mode dependencies per form; flags always updated
// - One word, long form two words
// - Shift bits 11-8, bit 7 indirect
// - Separate shift-sixteen direct and indirect encodings
// - Add with carry, operand unsigned
// - Add with carry sets or clears carry
// - Add with carry ignores sign mode
// - Cycle counts by operand and code placement
// - Same single-access block adds one cycle
// - Repeated counts n, n+nd, n+1+p+nd
// - Short form one or 1+p cycles
// - Long form two or 2+2p cycles
// - Magnitude negates negatives, clears carry
// - Magnitude of minimum: keep or saturate, flag
`timescale 1ns/1ps
module accumulator_add_unit #(
  parameter int rep_width = 8,
  parameter int cyc_width = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] accumulator_reg,
  output logic carry_flag,
  output logic overflow_flag,
  output logic busy,
  output logic [2:0] current_aux_pointer,
  output logic [15:0] operand_addr
);
  if (rep_width < 1 || rep_width > 32 || cyc_width < rep_width + 6) begin : g_width_check
    $error("cyc_width too small for rep_width");
  end

  accum_add_pkg::ctrl_t ctrl_reg;
  accum_add_pkg::op_kind_t kind_reg;
  accum_add_pkg::exec_state_t state_reg;
  logic [31:0] instr_reg;
  logic [15:0] operand_reg;
  logic [rep_width-1:0] rep_reg;
  logic [8:0] page_reg;
  logic [cyc_width-1:0] cyc_left_reg;
  logic [cyc_width-1:0] cyc_total_reg;
  logic [rep_width-1:0] iter_left_reg;
  logic [1:0] words_reg;
  logic [2:0] mod_reg;
  logic refused_reg;

  function automatic logic hit(input logic [11:0] a, input logic [7:0] off);
    return a == {4'h0, off};
  endfunction

  function automatic accum_add_pkg::op_kind_t decode(input logic [15:0] w);
    if (w[15:12] == accum_add_pkg::shift_hi) return accum_add_pkg::kind_shift;
    if (w[15:8] == accum_add_pkg::add16_hi) return accum_add_pkg::kind_shift16;
    if (w[15:8] == accum_add_pkg::accumulate_with_carry_op_hi) return accum_add_pkg::kind_accumulate_with_carry_op;
    if (w[15:8] == accum_add_pkg::short_hi) return accum_add_pkg::kind_short;
    if (w[15:4] == accum_add_pkg::long_hi) return accum_add_pkg::kind_long;
    if (w == accum_add_pkg::abs_word) return accum_add_pkg::kind_abs;
    return accum_add_pkg::kind_bad;
  endfunction

  function automatic logic mem_form(input accum_add_pkg::op_kind_t k);
    return k == accum_add_pkg::kind_shift || k == accum_add_pkg::kind_shift16 ||
           k == accum_add_pkg::kind_accumulate_with_carry_op;
  endfunction

  // Execution length in cycles for a given form, count and placement
  function automatic logic [cyc_width-1:0] cycles(input accum_add_pkg::op_kind_t k,
      input logic [rep_width-1:0] n, input accum_add_pkg::ctrl_t c);
    logic [cyc_width-1:0] nn;
    logic [cyc_width-1:0] pp;
    logic [cyc_width-1:0] dd;
    logic [cyc_width-1:0] t;
    nn = cyc_width'(n);
    pp = c.code_ext ? cyc_width'(c.prog_wait) : '0;
    dd = cyc_width'(c.data_wait);
    t = nn + pp;
    if (k == accum_add_pkg::kind_long) begin
      t = t + pp + cyc_width'(1);
    end else if (mem_form(k)) begin
      if (c.oper_ext) begin
        t = t + cyc_width'(nn * dd);
      end
      if (c.oper_ext && c.code_ext) begin
        t = t + cyc_width'(1);
      end
      if (c.same_block && !c.oper_ext && !c.code_ext) begin
        t = t + cyc_width'(1);
      end
    end
    return t;
  endfunction

  // Bus decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire sel_ctrl = hit(paddr, accum_add_pkg::ctrl_off);
  wire sel_instr = hit(paddr, accum_add_pkg::instr_off);
  wire sel_oper = hit(paddr, accum_add_pkg::operand_off);
  wire sel_rep = hit(paddr, accum_add_pkg::repeat_off);
  wire sel_acc = hit(paddr, accum_add_pkg::acc_off);
  wire sel_stat = hit(paddr, accum_add_pkg::status_off);
  wire sel_page = hit(paddr, accum_add_pkg::page_off);
  wire sel_cyc = hit(paddr, accum_add_pkg::cycles_off);
  wire mapped = sel_ctrl | sel_instr | sel_oper | sel_rep | sel_acc | sel_stat | sel_page | sel_cyc;
  // Writes that would disturb a running operation are refused
  wire busy_err = pwrite & busy & (sel_instr | sel_acc | sel_stat | sel_ctrl | sel_oper | sel_rep);
  wire wr_ok = access & pwrite & ~pslverr;
  wire [31:0] status_word = {operand_addr, 3'h0, mod_reg, words_reg, 1'b0, current_aux_pointer,
                             refused_reg, busy, overflow_flag, carry_flag};
  wire [31:0] rd_mux = sel_ctrl ? {16'h0, ctrl_reg} :
                       sel_instr ? instr_reg :
                       sel_oper ? {16'h0, operand_reg} :
                       sel_rep ? 32'(rep_reg) :
                       sel_acc ? accumulator_reg :
                       sel_stat ? status_word :
                       sel_page ? {23'h0, page_reg} :
                       sel_cyc ? 32'(cyc_total_reg) : 32'h0;

  // Start decode of a newly written instruction
  wire [15:0] w_new = pwdata[15:0];
  accum_add_pkg::op_kind_t k_new;
  assign k_new = decode(w_new);
  wire start = wr_ok & sel_instr;
  wire start_ok = start & (k_new != accum_add_pkg::kind_bad);
  wire ind_new = mem_form(k_new) & w_new[7];
  wire dir_new = mem_form(k_new) & ~w_new[7];
  wire rpt_bad = (k_new == accum_add_pkg::kind_short) & (rep_reg != '0);
  wire mod_bad = ind_new & (w_new[6:4] == accum_add_pkg::mod_reserved);
  wire refuse_set = start & ((k_new == accum_add_pkg::kind_bad) | rpt_bad | mod_bad);
  wire [rep_width-1:0] n_new = (rep_reg == '0 || k_new == accum_add_pkg::kind_short) ?
                               rep_width'(1) : rep_reg;
  wire [cyc_width-1:0] cyc_new = cycles(k_new, n_new, ctrl_reg);

  // Operand formation
  wire [15:0] iw = instr_reg[15:0];
  wire is_long = kind_reg == accum_add_pkg::kind_long;
  wire is_short = kind_reg == accum_add_pkg::kind_short;
  wire is_abs = kind_reg == accum_add_pkg::kind_abs;
  wire is_accumulate_with_carry_op = kind_reg == accum_add_pkg::kind_accumulate_with_carry_op;
  wire is_s16 = kind_reg == accum_add_pkg::kind_shift16;
  wire [3:0] sh_amt = is_long ? iw[3:0] : iw[11:8];
  wire [15:0] src = is_long ? instr_reg[31:16] : operand_reg;
  wire sxm_eff = ctrl_reg.sign_extend_mode & ~is_accumulate_with_carry_op & ~is_short;
  wire [31:0] src_ext = {{16{sxm_eff & src[15]}}, src};
  wire [31:0] opnd = is_short ? {24'h0, iw[7:0]} :
                     is_s16 ? {src, 16'h0} :
                     src_ext << sh_amt;
  wire cin = is_accumulate_with_carry_op & carry_flag;
  wire [32:0] sum = {1'b0, accumulator_reg} + {1'b0, opnd} + {32'h0, cin};
  wire add_ovf = (accumulator_reg[31] == opnd[31]) & (sum[31] != accumulator_reg[31]);
  wire sat = ctrl_reg.saturate_mode;
  wire [31:0] add_sat = accumulator_reg[31] ? accum_add_pkg::acc_min : accum_add_pkg::acc_max;
  wire [31:0] add_res = (add_ovf & sat) ? add_sat : sum[31:0];
  wire abs_min = accumulator_reg == accum_add_pkg::acc_min;
  wire [31:0] neg = ~accumulator_reg + 32'h1;
  wire [31:0] abs_res = abs_min ? (sat ? accum_add_pkg::acc_max : accum_add_pkg::acc_min) :
                        accumulator_reg[31] ? neg : accumulator_reg;
  wire [31:0] res = is_abs ? abs_res : add_res;
  wire carry_res = is_abs ? 1'b0 :
                   is_s16 ? (carry_flag | sum[32]) :
                   sum[32];
  wire ovf_set_ev = is_abs ? abs_min : add_ovf;
  // Iterations land in the final cycles of the execution window
  wire apply = (state_reg == accum_add_pkg::st_exec) &
               (cyc_left_reg <= cyc_width'(iter_left_reg));
  wire last = (state_reg == accum_add_pkg::st_exec) & (cyc_left_reg == cyc_width'(1));

  wire ovf_set = apply & ovf_set_ev;
  wire ovf_clr = wr_ok & sel_stat & pwdata[accum_add_pkg::st_ovf];
  wire ref_clr = wr_ok & sel_stat & pwdata[accum_add_pkg::st_refused];
  wire [31:0] acc_next = apply ? res : (wr_ok & sel_acc) ? pwdata : accumulator_reg;
  wire carry_next = apply ? carry_res : (wr_ok & sel_stat) ? pwdata[accum_add_pkg::st_carry] : carry_flag;

  // Bus response, registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (clk_en) begin
      pready <= setup;
      pslverr <= setup & (~mapped | busy_err);
      prdata <= (setup & ~pwrite & mapped) ? rd_mux : 32'h0;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= accum_add_pkg::ctrl_rst;
      operand_reg <= 16'h0;
      rep_reg <= '0;
      page_reg <= accum_add_pkg::page_rst;
    end else if (clk_en && wr_ok) begin
      if (sel_ctrl) ctrl_reg <= pwdata[15:0] & accum_add_pkg::ctrl_mask;
      if (sel_oper) operand_reg <= pwdata[15:0];
      if (sel_rep) rep_reg <= pwdata[rep_width-1:0];
      if (sel_page) page_reg <= pwdata[8:0];
    end
  end

  // Accumulator and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator_reg <= accum_add_pkg::acc_rst;
      carry_flag <= 1'b0;
      overflow_flag <= 1'b0;
      refused_reg <= 1'b0;
    end else if (clk_en) begin
      accumulator_reg <= acc_next;
      carry_flag <= carry_next;
      overflow_flag <= ovf_set | (overflow_flag & ~ovf_clr);
      refused_reg <= refuse_set | (refused_reg & ~ref_clr);
    end
  end

  // Execution sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= accum_add_pkg::st_idle;
      busy <= 1'b0;
      kind_reg <= accum_add_pkg::kind_abs;
      instr_reg <= 32'h0;
      cyc_left_reg <= '0;
      cyc_total_reg <= '0;
      iter_left_reg <= '0;
      words_reg <= accum_add_pkg::words_one;
      mod_reg <= 3'h0;
      current_aux_pointer <= 3'h0;
      operand_addr <= 16'h0;
    end else if (clk_en) begin
      if (start_ok) begin
        state_reg <= accum_add_pkg::st_exec;
        busy <= 1'b1;
        kind_reg <= k_new;
        instr_reg <= pwdata;
        cyc_left_reg <= cyc_new;
        cyc_total_reg <= cyc_new;
        iter_left_reg <= n_new;
        words_reg <= (k_new == accum_add_pkg::kind_long) ? accum_add_pkg::words_two :
                     accum_add_pkg::words_one;
        if (dir_new) operand_addr <= {page_reg, w_new[6:0]};
        if (ind_new) mod_reg <= w_new[6:4];
        if (ind_new && w_new[3]) current_aux_pointer <= w_new[2:0];
      end else if (state_reg == accum_add_pkg::st_exec) begin
        cyc_left_reg <= cyc_left_reg - cyc_width'(1);
        if (apply) iter_left_reg <= iter_left_reg - rep_width'(1);
        if (last) begin
          state_reg <= accum_add_pkg::st_idle;
          busy <= 1'b0;
        end
      end
    end
  end

  // Checks
  logic [cyc_width-1:0] busy_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt <= '0;
    else if (clk_en) busy_cnt <= start_ok ? '0 : busy ? busy_cnt + cyc_width'(1) : busy_cnt;
  end

  default clocking cb @(posedge pclk iff clk_en); endclocking
  default disable iff (!presetn);

  exec_length_a: assert property ($fell(busy) |-> busy_cnt == cyc_total_reg)
    else $error("execution length differs from cycle count");
  abs_min_a: assert property (apply && is_abs && abs_min |=> overflow_flag &&
      accumulator_reg == ($past(sat) ? accum_add_pkg::acc_max : accum_add_pkg::acc_min))
    else $error("magnitude of minimum wrong");
  abs_carry_a: assert property (apply && is_abs |=> !carry_flag)
    else $error("magnitude left carry set");
  abs_neg_a: assert property (apply && is_abs && accumulator_reg[31] && !abs_min |=>
      accumulator_reg == 32'(-$signed($past(accumulator_reg))))
    else $error("magnitude result wrong");
  short_imm_a: assert property (apply && is_short && !add_ovf |=>
      accumulator_reg == $past(accumulator_reg) + {24'h0, $past(iw[7:0])})
    else $error("short constant not unshifted low byte");
  zero_fill_a: assert property (apply && !is_abs && !is_short |->
      (opnd & ((32'h1 << sh_amt) - 32'h1)) == 32'h0)
    else $error("low bits not zero filled");
  carry_keep_a: assert property (apply && is_s16 && carry_flag |=> carry_flag)
    else $error("shift sixteen cleared carry");
  carry_clear_a: assert property (apply && kind_reg == accum_add_pkg::kind_shift && !sum[32] |=> !carry_flag)
    else $error("carry not cleared");
  sat_range_a: assert property (apply && !is_abs && add_ovf && sat |=> overflow_flag &&
      (accumulator_reg == accum_add_pkg::acc_max || accumulator_reg == accum_add_pkg::acc_min))
    else $error("overflow not saturated");
  long_words_a: assert property (start_ok && k_new == accum_add_pkg::kind_long |=> words_reg == 2'h2)
    else $error("long form word count wrong");
  page_addr_a: assert property (start_ok && dir_new |=> operand_addr == {$past(page_reg), $past(w_new[6:0])})
    else $error("direct address wrong");
  aux_next_a: assert property (start_ok && ind_new && w_new[3] |=> current_aux_pointer == $past(w_new[2:0]))
    else $error("aux pointer not updated");

  // Reference values formed apart from the datapath
  wire [32:0] accumulate_with_carry_op_ref = {1'b0, accumulator_reg} + {17'h0, operand_reg} + {32'h0, carry_flag};
  wire signed [31:0] opnd_s = opnd;
  wire is_plain = kind_reg == accum_add_pkg::kind_shift;
  wire shift_form = is_plain | is_long;

  carry_set_a: assert property (apply && is_plain && sum[32] |=> carry_flag)
    else $error("carry not set");
  s16_carry_a: assert property (apply && is_s16 && sum[32] |=> carry_flag)
    else $error("shift sixteen carry not set");
  accumulate_with_carry_op_carry_a: assert property (apply && is_accumulate_with_carry_op |=> carry_flag == $past(accumulate_with_carry_op_ref[32]))
    else $error("carry after add with carry wrong");
  accumulate_with_carry_op_sum_a: assert property (apply && is_accumulate_with_carry_op && !add_ovf |=>
      accumulator_reg == $past(accumulate_with_carry_op_ref[31:0]))
    else $error("add with carry result wrong");
  sxm_ignore_a: assert property (apply && (is_short || is_accumulate_with_carry_op) |-> opnd[31:16] == 16'h0)
    else $error("sign mode leaked into operand");
  zero_high_a: assert property (apply && shift_form && !ctrl_reg.sign_extend_mode |->
      (opnd >> sh_amt) == {16'h0, src})
    else $error("upper bits not zero filled");
  sign_high_a: assert property (apply && shift_form && ctrl_reg.sign_extend_mode |->
      (opnd_s >>> sh_amt) == $signed({{16{src[15]}}, src}))
    else $error("upper bits not sign filled");
  refuse_rpt_a: assert property (start && k_new == accum_add_pkg::kind_short && rep_reg != '0 |=>
      refused_reg)
    else $error("repeated short form not flagged");
  short_once_a: assert property (start_ok && k_new == accum_add_pkg::kind_short |=>
      iter_left_reg == rep_width'(1))
    else $error("short form repeated");
  refuse_mod_a: assert property (start && mod_bad |=> refused_reg)
    else $error("reserved modifier not flagged");
  refuse_bad_a: assert property (start && k_new == accum_add_pkg::kind_bad |=> refused_reg && !busy)
    else $error("unknown opcode executed");
  words_one_a: assert property (start_ok && k_new != accum_add_pkg::kind_long |=> words_reg == 2'h1)
    else $error("one word form count wrong");
  aux_hold_a: assert property (start_ok && !(ind_new && w_new[3]) |=> $stable(current_aux_pointer))
    else $error("aux pointer changed without field");
  iter_done_a: assert property ($fell(busy) |-> iter_left_reg == '0)
    else $error("iterations left at end");
  abs_pos_a: assert property (apply && is_abs && !accumulator_reg[31] |=> $stable(accumulator_reg))
    else $error("magnitude changed positive value");
  ovf_sticky_a: assert property (overflow_flag && !ovf_clr |=> overflow_flag)
    else $error("overflow flag lost");

  // Bus and clock enable checks
  busy_refuse_a: assert property (setup && pwrite && busy && sel_acc |=> pslverr)
    else $error("write while busy not refused");
  unmapped_a: assert property (setup && !mapped |=> pready && pslverr)
    else $error("unmapped access not refused");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  freeze_a: assert property (@(posedge pclk) disable iff (!presetn) !clk_en |=>
      $stable(accumulator_reg) && $stable(busy) && $stable(pready))
    else $error("state moved while clock enable low");

  abs_min_c: cover property (apply && is_abs && abs_min);
  repeat_c: cover property (start_ok && n_new > rep_width'(1) ##[1:20] $fell(busy));
  long_c: cover property (apply && is_long && sh_amt != 4'h0);
  ext_both_c: cover property (start_ok && ctrl_reg.oper_ext && ctrl_reg.code_ext);
  freeze_c: cover property (@(posedge pclk) busy && !clk_en);
endmodule

/* File: dv/data_mem_model.sv */
// Data memory model that answers operand reads by full address
`timescale 1ns/1ps
module data_mem_model;
  // Unlisted words return the inverted address, so a wrong page never matches
  function automatic logic [15:0] fetch(input logic [15:0] addr);
    case (addr)
      16'h0301: fetch = 16'h0001;
      default: fetch = ~addr;
    endcase
  endfunction
endmodule

/* File: dv/tb.sv */
// Self-checking testbench of the accumulator add unit
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] a_ctl = accum_add_pkg::ctrl_off;
  localparam logic [7:0] a_ins = accum_add_pkg::instr_off;
  localparam logic [7:0] a_opd = accum_add_pkg::operand_off;
  localparam logic [7:0] a_rep = accum_add_pkg::repeat_off;
  localparam logic [7:0] a_acc = accum_add_pkg::acc_off;
  localparam logic [7:0] a_st = accum_add_pkg::status_off;
  localparam logic [7:0] a_pg = accum_add_pkg::page_off;
  localparam logic [7:0] a_cy = accum_add_pkg::cycles_off;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, acc, rd;
  logic pready, pslverr, carry, ovf, busy, err;
  logic [2:0] aux;
  logic [15:0] oaddr;
  logic [31:0] ct[8], ins[8];
  logic [2:0] mods[8];
  int rp[8], cy[8];
  int bad_count = 0;
  int n_checks = 0;
  int ncyc;
  always #2.5 pclk = ~pclk;
  accumulator_add_unit u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accumulator_reg(acc), .carry_flag(carry), .overflow_flag(ovf), .busy(busy),
    .current_aux_pointer(aux), .operand_addr(oaddr));
  data_mem_model u_mem ();
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang();
    bad_count++;
    summarize();
  endtask
  // Request held from setup until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitb();
    int k;
    k = 0;
    ncyc = 0;
    do begin
      @(posedge pclk);
      k++;
      if (busy === 1'b1) ncyc++;
    end while (busy !== 1'b0 && k < 300);
    if (k >= 300) hang();
  endtask
  task automatic exec(input logic [31:0] w);
    apb(1'b1, a_ins, w);
    waitb();
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(nm, e, rd & m);
  endtask
  task automatic prep(input logic [31:0] c, input logic [31:0] a0, input logic [15:0] o, input logic c0,
    input logic [7:0] r);
    apb(1'b1, a_ctl, c);
    apb(1'b1, a_acc, a0);
    apb(1'b1, a_opd, {16'h0000, o});
    apb(1'b1, a_rep, {24'h000000, r});
    // Clears both sticky flags and loads the carry
    apb(1'b1, a_st, {28'h0000000, 3'h5, c0});
  endtask
  task automatic res(input logic [31:0] e, input logic c, input logic v);
    chk("acc", e, acc);
    chk("carry", {31'h0, c}, {31'h0, carry});
    chk("overflow", {31'h0, v}, {31'h0, ovf});
  endtask
  initial begin
    mods = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
    ct = '{32'h2020, 32'h2330, 32'h0040, 32'h2020, 32'h2330, 32'h0040, 32'h0310, 32'h0310};
    rp = '{0, 0, 0, 3, 3, 3, 0, 0};
    cy = '{3, 7, 2, 9, 13, 4, 4, 8};
    ins = '{32'h2001, 32'h2001, 32'h2001, 32'h2001, 32'h2001, 32'h2001, 32'hb801, 32'h0001bf90};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", a_ctl, 32'hffffffff, 32'h0);
    rdc("acc reg", a_acc, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, a_pg, 32'h6);
    prep(32'h0, 32'h2, u_mem.fetch(16'h0301), 1'b0, 8'h0);
    exec(32'h2101);
    res(32'h4, 1'b0, 1'b0);
    chk("operand addr", 32'h0301, {16'h0, oaddr});
    chk("cycles", 32'h1, ncyc);
    rdc("words", a_st, 32'h300, 32'h100);
    prep(32'h1, 32'h0, 16'h8000, 1'b0, 8'h0);
    exec(32'h2401);
    res(32'hfff80000, 1'b0, 1'b0);
    prep(32'h0, 32'h0, 16'hffff, 1'b0, 8'h0);
    exec(32'h2f01);
    res(32'h7fff8000, 1'b0, 1'b0);
    prep(32'h0, 32'hffffffff, 16'h1, 1'b0, 8'h0);
    exec(32'h2001);
    res(32'h0, 1'b1, 1'b0);
    prep(32'h0, 32'h0, 16'h0, 1'b1, 8'h0);
    exec(32'h2001);
    res(32'h0, 1'b0, 1'b0);
    prep(32'h0, 32'h0, 16'h1, 1'b1, 8'h0);
    exec(32'h6101);
    res(32'h00010000, 1'b1, 1'b0);
    prep(32'h0, 32'hffff0000, 16'h1, 1'b0, 8'h0);
    exec(32'h618d);
    res(32'h0, 1'b1, 1'b0);
    chk("aux", 32'h5, {29'h0, aux});
    prep(32'h0, 32'h0, 16'h1, 1'b0, 8'h0);
    for (int i = 0; i < 8; i++) begin
      exec({16'h0, 4'h2, 4'h0, 1'b1, mods[i], 1'b1, i[2:0]});
      chk("aux", i, {29'h0, aux});
      chk("acc", i + 1, acc);
      rdc("modifier", a_st, 32'h1c08, {19'h0, mods[i], 10'h0});
    end
    exec(32'h20ba);
    chk("acc", 32'h9, acc);
    rdc("refused", a_st, 32'h8, 32'h8);
    prep(32'h1, 32'h2, 16'h0, 1'b0, 8'h0);
    exec(32'hb801);
    exec(32'hb880);
    res(32'h83, 1'b0, 1'b0);
    prep(32'h0, 32'h0, 16'h0, 1'b0, 8'h2);
    exec(32'hb801);
    chk("acc", 32'h1, acc);
    rdc("refused", a_st, 32'h8, 32'h8);
    prep(32'h1, 32'h2, 16'h0, 1'b0, 8'h0);
    exec(32'h1111bf91);
    res(32'h2224, 1'b0, 1'b0);
    rdc("words", a_st, 32'h300, 32'h200);
    exec(32'h8000bf90);
    res(32'hffffa224, 1'b0, 1'b0);
    prep(32'h1, 32'h13, 16'h4, 1'b1, 8'h0);
    exec(32'h6001);
    res(32'h18, 1'b0, 1'b0);
    prep(32'h1, 32'hffffffff, 16'h0, 1'b1, 8'h0);
    exec(32'h6001);
    res(32'h0, 1'b1, 1'b0);
    prep(32'h1, 32'h0, 16'h8000, 1'b0, 8'h0);
    exec(32'h6001);
    res(32'h8000, 1'b0, 1'b0);
    prep(32'h2, 32'h7fffffff, 16'h1, 1'b0, 8'h0);
    exec(32'h6001);
    res(32'h7fffffff, 1'b0, 1'b1);
    prep(32'h0, 32'h7fffffff, 16'h1, 1'b0, 8'h0);
    exec(32'h2001);
    res(32'h80000000, 1'b0, 1'b1);
    prep(32'h3, 32'h80000000, 16'hffff, 1'b0, 8'h0);
    exec(32'h2001);
    res(32'h80000000, 1'b1, 1'b1);
    prep(32'h0, 32'hffffffff, 16'h0, 1'b1, 8'h0);
    exec(32'hbe00);
    res(32'h1, 1'b0, 1'b0);
    prep(32'h0, 32'h1234, 16'h0, 1'b1, 8'h0);
    exec(32'hbe00);
    res(32'h1234, 1'b0, 1'b0);
    prep(32'h0, 32'h80000000, 16'h0, 1'b1, 8'h0);
    exec(32'hbe00);
    res(32'h80000000, 1'b0, 1'b1);
    prep(32'h2, 32'h80000000, 16'h0, 1'b0, 8'h0);
    exec(32'hbe00);
    res(32'h7fffffff, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      prep(ct[i], 32'h0, 16'h1, 1'b0, rp[i][7:0]);
      exec(ins[i]);
      chk("busy cycles", cy[i], ncyc);
      rdc("cycle reg", a_cy, 32'hffff, cy[i]);
      chk("acc", (rp[i] == 0) ? 1 : rp[i], acc);
    end
    prep(32'h2330, 32'h0, 16'h1, 1'b0, 8'h3);
    apb(1'b1, a_ins, 32'h2001);
    apb(1'b1, a_acc, 32'h5);
    chk("busy write", 32'h1, {31'h0, err});
    waitb();
    chk("acc", 32'h3, acc);
    exec(32'hffff);
    chk("busy cycles", 32'h0, ncyc);
    rdc("refused", a_st, 32'h8, 32'h8);
    // Clock enable low at the start of execution must freeze the sequencer
    prep(32'h2020, 32'h0, 16'h1, 1'b0, 8'h0);
    apb(1'b1, a_ins, 32'h2001);
    clk_en <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("frozen busy", 32'h1, {31'h0, busy});
    chk("frozen acc", 32'h0, acc);
    clk_en <= 1'b1;
    waitb();
    chk("busy cycles", 32'h3, ncyc);
    chk("acc", 32'h1, acc);
    summarize();
  end
endmodule
